/* hdl/timer_pwm_defines.vh */
/*
 * register offsets, field positions, reset values of the event timer.
 * assumes a 12-bit byte address from an apb slave port.
 */
`ifndef TIMER_PWM_DEFINES_VH
`define TIMER_PWM_DEFINES_VH
`define OFS_CONFIG 12'h000
`define OFS_CTRL 12'h004
`define OFS_COUNT 12'h008
`define OFS_STATE 12'h00c
`define OFS_INPUT 12'h010
`define OFS_OUTPUT 12'h014
`define OFS_REGMODE 12'h018
`define OFS_EVFLAG 12'h01c
`define OFS_INSEL 12'h020
`define OFS_DMAEN 12'h024
`define OFS_ADCSEL 12'h028
`define OFS_IRQEN 12'h02c
`define OFS_LIMIT 12'h030
`define OFS_HALT 12'h034
`define OFS_STOP 12'h038
`define OFS_START 12'h03c
`define GRP_MATCH 4'h1
`define GRP_CAPCTRL 4'h1
`define GRP_EVENT 4'h2
`define GRP_OUTACT 4'h3
`define CFG_UNIFY 0
`define CFG_CKIN 1
`define CFG_CKSEL_LSB 2
`define CFG_AUTOLIM_L 4
`define CFG_AUTOLIM_H 5
`define CTL_STOP 0
`define CTL_HALT 1
`define CTL_CLR 2
`define CTL_BIDIR 3
`define CTL_H_OFS 16
`define EV_MSEL_MSB 2
`define EV_HSIDE 4
`define EV_IOIDX_LSB 5
`define EV_IOOUT 8
`define EV_IOCOND_LSB 10
`define EV_COMB_LSB 12
`define EV_STLD 14
`define EV_STVAL_LSB 15
`define EV_MMEM 20
`define EV_DIR_LSB 21
`define CTRL_RESET 32'h00020002
`define RESET_ZERO 32'h00000000
`define SRC_COUNT 8
`endif

/* hdl/event_timer_pwm.v */
/*
 * event driven timer with pwm outputs, match/capture pool, state
 * sequencer and input selectors behind an apb slave.
 * assumes pclk at 200 mhz; pins and internal sources are asynchronous.
 */
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "timer_pwm_defines.vh"

module event_timer_pwm #(
  parameter NREG = 8,
  parameter NEV = 8,
  parameter NOUT = 6,
  parameter NIN = 4
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  // selector sources
  input wire [3:0] route_pin,
  input wire adc_thcmp_irq,
  input wire cmp_out,
  input wire core_event_out,
  input wire debug_halt_status,
  // outputs
  output reg [NOUT-1:0] timer_out_q,
  output reg adc_trig_q,
  output reg dma_req_q,
  output reg event_irq_q
);

  integer i;
  reg [31:0] cfg_q;
  reg [31:0] ctrl_q;
  reg [31:0] cnt_q;
  reg [1:0] dir_q;
  reg [2:0] state_l_q;
  reg [2:0] state_h_q;
  reg [NREG-1:0] regmode_q;
  reg [NEV-1:0] flag_q;
  reg [11:0] insel_q;
  reg [NEV-1:0] dmaen_q;
  reg [2:0] adcsel_q;
  reg [NEV-1:0] irqen_q;
  reg [31:0] limit_q;
  reg [31:0] halt_q;
  reg [31:0] stop_q;
  reg [31:0] start_q;
  reg [31:0] match_q [0:NREG-1];
  reg [NEV-1:0] capctrl_q [0:NREG-1];
  reg [7:0] evstate_q [0:NEV-1];
  reg [23:0] evctrl_q [0:NEV-1];
  reg [NEV-1:0] oset_q [0:NOUT-1];
  reg [NEV-1:0] oclr_q [0:NOUT-1];
  reg [NEV-1:0] mem_q;
  reg [7:0] sync1_q;
  reg [7:0] sync2_q;
  reg [NIN-1:0] in_q;
  reg [NIN-1:0] in_prev_q;
  reg [NOUT-1:0] out_prev_q;

  wire [7:0] src_raw;
  wire wr_en;
  wire setup;
  wire unify;
  wire tick;
  wire [3:0] grp;
  reg [NREG-1:0] hit_l;
  reg [NREG-1:0] hit_h;
  reg [NEV-1:0] ev;
  reg [NEV-1:0] msrc;
  reg [31:0] rd_d;
  reg err_d;
  reg m;
  reg io;
  reg lvl;
  reg prv;
  reg okdir;
  reg hs;
  reg [2:0] st;
  reg [32:0] nx_l;
  reg [32:0] nx_h;
  reg [32:0] nx_u;
  reg lim_l;
  reg lim_h;

  assign src_raw = {debug_halt_status, core_event_out, cmp_out, adc_thcmp_irq, route_pin};
  assign setup = psel & ~penable & ~pready_q;
  assign wr_en = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign unify = cfg_q[`CFG_UNIFY];
  assign grp = paddr[11:8];
  // counting edge: system clock, or rising edge of a selected input
  assign tick = ~cfg_q[`CFG_CKIN] |
    (in_q[cfg_q[`CFG_CKSEL_LSB+1:`CFG_CKSEL_LSB]] & ~in_prev_q[cfg_q[`CFG_CKSEL_LSB+1:`CFG_CKSEL_LSB]]);

  // up or up-down step: returns {direction, next count}
  function [32:0] step;
    input [31:0] c;
    input d;
    input lim;
    input bi;
    begin
      if (!d) begin
        if (lim) begin
          step = bi ? {1'b1, c - 32'h1} : {1'b0, 32'h0};
        end else begin
          step = {1'b0, c + 32'h1};
        end
      end else if (c == 32'h0) begin
        step = {1'b0, c + 32'h1};
      end else begin
        step = {1'b1, c - 32'h1};
      end
    end
  endfunction

  // two-flop sync of every source, then per-input selection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      in_q <= {NIN{1'b0}};
      in_prev_q <= {NIN{1'b0}};
      out_prev_q <= {NOUT{1'b0}};
    end else begin
      sync1_q <= src_raw;
      sync2_q <= sync1_q;
      for (i = 0; i < NIN; i = i + 1) begin
        in_q[i] <= sync2_q[insel_q[3*i +: 3]];
      end
      in_prev_q <= in_q;
      out_prev_q <= timer_out_q;
    end
  end

  // match compare and event build
  always @* begin
    m = 1'b0;
    io = 1'b0;
    lvl = 1'b0;
    prv = 1'b0;
    okdir = 1'b0;
    hs = 1'b0;
    st = 3'h0;
    for (i = 0; i < NREG; i = i + 1) begin
      hit_l[i] = ~regmode_q[i] & (unify ? (cnt_q == match_q[i]) :
        (cnt_q[15:0] == match_q[i][15:0]));
      hit_h[i] = ~regmode_q[i] & ~unify & (cnt_q[31:16] == match_q[i][31:16]);
    end
    for (i = 0; i < NEV; i = i + 1) begin
      hs = evctrl_q[i][`EV_HSIDE] & ~unify;
      msrc[i] = hs ? hit_h[evctrl_q[i][`EV_MSEL_MSB:0]] : hit_l[evctrl_q[i][`EV_MSEL_MSB:0]];
      m = msrc[i] | (evctrl_q[i][`EV_MMEM] & mem_q[i]);
      if (evctrl_q[i][`EV_IOOUT]) begin
        lvl = timer_out_q[evctrl_q[i][`EV_IOIDX_LSB+2:`EV_IOIDX_LSB]];
        prv = out_prev_q[evctrl_q[i][`EV_IOIDX_LSB+2:`EV_IOIDX_LSB]];
      end else begin
        lvl = in_q[evctrl_q[i][`EV_IOIDX_LSB+1:`EV_IOIDX_LSB]];
        prv = in_prev_q[evctrl_q[i][`EV_IOIDX_LSB+1:`EV_IOIDX_LSB]];
      end
      case (evctrl_q[i][`EV_IOCOND_LSB+1:`EV_IOCOND_LSB])
        2'h0: io = ~lvl;
        2'h1: io = lvl & ~prv;
        2'h2: io = ~lvl & prv;
        default: io = lvl;
      endcase
      st = hs ? state_h_q : state_l_q;
      case (evctrl_q[i][`EV_DIR_LSB+1:`EV_DIR_LSB])
        2'h1: okdir = ~dir_q[hs];
        2'h2: okdir = dir_q[hs];
        default: okdir = 1'b1;
      endcase
      case (evctrl_q[i][`EV_COMB_LSB+1:`EV_COMB_LSB])
        2'h0: ev[i] = m | io;
        2'h1: ev[i] = m;
        2'h2: ev[i] = io;
        default: ev[i] = m & io;
      endcase
      ev[i] = ev[i] & evstate_q[i][st] & okdir;
    end
    lim_l = (|(ev & limit_q[NEV-1:0])) | (cfg_q[`CFG_AUTOLIM_L] & hit_l[0]);
    lim_h = (|(ev & limit_q[16 +: NEV])) | (cfg_q[`CFG_AUTOLIM_H] & hit_h[0]);
    nx_u = step(cnt_q, dir_q[0], lim_l, ctrl_q[`CTL_BIDIR]);
    nx_l = step({16'h0, cnt_q[15:0]}, dir_q[0], lim_l, ctrl_q[`CTL_BIDIR]);
    nx_h = step({16'h0, cnt_q[31:16]}, dir_q[1], lim_h, ctrl_q[`CTL_H_OFS+`CTL_BIDIR]);
  end

  // counters, run control and states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= `RESET_ZERO;
      dir_q <= 2'h0;
      ctrl_q <= `CTRL_RESET;
      state_l_q <= 3'h0;
      state_h_q <= 3'h0;
      mem_q <= {NEV{1'b0}};
    end else begin
      if (wr_en && paddr == `OFS_CTRL) begin
        ctrl_q <= pwdata & ~(32'h1 << `CTL_CLR) & ~(32'h1 << (`CTL_H_OFS + `CTL_CLR));
      end
      // hardware halt/stop win over a software write in the same cycle
      for (i = 0; i < NEV; i = i + 1) begin
        if (ev[i] & halt_q[i]) ctrl_q[`CTL_HALT] <= 1'b1;
        if (ev[i] & halt_q[16+i]) ctrl_q[`CTL_H_OFS+`CTL_HALT] <= 1'b1;
        if (ev[i] & start_q[i]) ctrl_q[`CTL_STOP] <= 1'b0;
        if (ev[i] & start_q[16+i]) ctrl_q[`CTL_H_OFS+`CTL_STOP] <= 1'b0;
        if (ev[i] & stop_q[i]) ctrl_q[`CTL_STOP] <= 1'b1;
        if (ev[i] & stop_q[16+i]) ctrl_q[`CTL_H_OFS+`CTL_STOP] <= 1'b1;
      end
      if (tick && !(ctrl_q[`CTL_STOP] | ctrl_q[`CTL_HALT])) begin
        if (unify) begin
          cnt_q <= nx_u[31:0];
          dir_q[0] <= nx_u[32];
        end else begin
          cnt_q[15:0] <= nx_l[15:0];
          dir_q[0] <= nx_l[32];
        end
      end
      if (!unify && tick && !(ctrl_q[`CTL_H_OFS+`CTL_STOP] | ctrl_q[`CTL_H_OFS+`CTL_HALT])) begin
        cnt_q[31:16] <= nx_h[15:0];
        dir_q[1] <= nx_h[32];
      end
      // software load of the count wins over a step in the same cycle
      if (wr_en && paddr == `OFS_COUNT) cnt_q <= pwdata;
      if (wr_en && paddr == `OFS_CTRL && pwdata[`CTL_CLR]) begin
        cnt_q[15:0] <= 16'h0000;
        if (unify) cnt_q[31:16] <= 16'h0000;
        dir_q[0] <= 1'b0;
      end
      if (wr_en && paddr == `OFS_CTRL && pwdata[`CTL_H_OFS+`CTL_CLR]) begin
        cnt_q[31:16] <= 16'h0000;
        dir_q[1] <= 1'b0;
      end
      // held matches reload from the current match on their counter's limit
      for (i = 0; i < NEV; i = i + 1) begin
        if ((evctrl_q[i][`EV_HSIDE] & ~unify) ? lim_h : lim_l) begin
          mem_q[i] <= msrc[i];
        end else if (msrc[i]) begin
          mem_q[i] <= 1'b1;
        end
      end
      if (wr_en && paddr == `OFS_STATE) begin
        state_l_q <= pwdata[2:0];
        state_h_q <= pwdata[18:16];
      end
      // lowest event number has the last word on the next state
      for (i = NEV - 1; i >= 0; i = i - 1) begin
        if (ev[i]) begin
          if (evctrl_q[i][`EV_HSIDE] & ~unify) begin
            state_h_q <= evctrl_q[i][`EV_STLD] ? evctrl_q[i][`EV_STVAL_LSB +: 3] :
              state_h_q + evctrl_q[i][`EV_STVAL_LSB +: 3];
          end else begin
            state_l_q <= evctrl_q[i][`EV_STLD] ? evctrl_q[i][`EV_STVAL_LSB +: 3] :
              state_l_q + evctrl_q[i][`EV_STVAL_LSB +: 3];
          end
        end
      end
    end
  end

  // configuration, match/capture pool, event and output tables
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= `RESET_ZERO;
      regmode_q <= {NREG{1'b0}};
      flag_q <= {NEV{1'b0}};
      insel_q <= 12'h000;
      dmaen_q <= {NEV{1'b0}};
      adcsel_q <= 3'h0;
      irqen_q <= {NEV{1'b0}};
      limit_q <= `RESET_ZERO;
      halt_q <= `RESET_ZERO;
      stop_q <= `RESET_ZERO;
      start_q <= `RESET_ZERO;
      for (i = 0; i < NREG; i = i + 1) begin
        match_q[i] <= `RESET_ZERO;
        capctrl_q[i] <= {NEV{1'b0}};
      end
      for (i = 0; i < NEV; i = i + 1) begin
        evstate_q[i] <= 8'h00;
        evctrl_q[i] <= 24'h000000;
      end
      for (i = 0; i < NOUT; i = i + 1) begin
        oset_q[i] <= {NEV{1'b0}};
        oclr_q[i] <= {NEV{1'b0}};
      end
    end else begin
      if (wr_en) begin
        case (paddr)
          `OFS_CONFIG: cfg_q <= pwdata;
          `OFS_REGMODE: regmode_q <= pwdata[NREG-1:0];
          `OFS_INSEL: insel_q <= pwdata[11:0];
          `OFS_DMAEN: dmaen_q <= pwdata[NEV-1:0];
          `OFS_ADCSEL: adcsel_q <= pwdata[2:0];
          `OFS_IRQEN: irqen_q <= pwdata[NEV-1:0];
          `OFS_LIMIT: limit_q <= pwdata;
          `OFS_HALT: halt_q <= pwdata;
          `OFS_STOP: stop_q <= pwdata;
          `OFS_START: start_q <= pwdata;
          default: ;
        endcase
        if (grp == `GRP_MATCH && !paddr[7]) match_q[paddr[4:2]] <= pwdata;
        if (grp == `GRP_CAPCTRL && paddr[7]) capctrl_q[paddr[4:2]] <= pwdata[NEV-1:0];
        if (grp == `GRP_EVENT && !paddr[2]) evstate_q[paddr[5:3]] <= pwdata[7:0];
        if (grp == `GRP_EVENT && paddr[2]) evctrl_q[paddr[5:3]] <= pwdata[23:0];
        if (grp == `GRP_OUTACT && !paddr[2] && paddr[5:3] < NOUT) begin
          oset_q[paddr[5:3]] <= pwdata[NEV-1:0];
        end
        if (grp == `GRP_OUTACT && paddr[2] && paddr[5:3] < NOUT) begin
          oclr_q[paddr[5:3]] <= pwdata[NEV-1:0];
        end
      end
      // capture beats a software write of the same register
      for (i = 0; i < NREG; i = i + 1) begin
        if (regmode_q[i] && (|(capctrl_q[i] & ev))) match_q[i] <= cnt_q;
      end
      // flags: write one to clear, a new event in that cycle wins
      flag_q <= (flag_q & ~((wr_en && paddr == `OFS_EVFLAG) ? pwdata[NEV-1:0] : {NEV{1'b0}})) | ev;
    end
  end

  // outputs, pwm drive and requests
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_out_q <= {NOUT{1'b0}};
      adc_trig_q <= 1'b0;
      dma_req_q <= 1'b0;
      event_irq_q <= 1'b0;
    end else begin
      for (i = 0; i < NOUT; i = i + 1) begin
        if (|(ev & oset_q[i]) && |(ev & oclr_q[i])) begin
          timer_out_q[i] <= ~timer_out_q[i];
        end else if (|(ev & oset_q[i])) begin
          timer_out_q[i] <= 1'b1;
        end else if (|(ev & oclr_q[i])) begin
          timer_out_q[i] <= 1'b0;
        end else if (wr_en && paddr == `OFS_OUTPUT) begin
          timer_out_q[i] <= pwdata[i];
        end
      end
      adc_trig_q <= (adcsel_q < NOUT) ? timer_out_q[adcsel_q] : 1'b0;
      dma_req_q <= |(ev & dmaen_q);
      event_irq_q <= |(flag_q & irqen_q);
    end
  end

  // read decode
  always @* begin
    rd_d = 32'h00000000;
    err_d = 1'b0;
    case (paddr)
      `OFS_CONFIG: rd_d = cfg_q;
      `OFS_CTRL: rd_d = ctrl_q;
      `OFS_COUNT: rd_d = cnt_q;
      `OFS_STATE: rd_d = {13'h0000, state_h_q, 13'h0000, state_l_q};
      `OFS_INPUT: rd_d[NIN-1:0] = in_q;
      `OFS_OUTPUT: rd_d[NOUT-1:0] = timer_out_q;
      `OFS_REGMODE: rd_d[NREG-1:0] = regmode_q;
      `OFS_EVFLAG: rd_d[NEV-1:0] = flag_q;
      `OFS_INSEL: rd_d[11:0] = insel_q;
      `OFS_DMAEN: rd_d[NEV-1:0] = dmaen_q;
      `OFS_ADCSEL: rd_d[2:0] = adcsel_q;
      `OFS_IRQEN: rd_d[NEV-1:0] = irqen_q;
      `OFS_LIMIT: rd_d = limit_q;
      `OFS_HALT: rd_d = halt_q;
      `OFS_STOP: rd_d = stop_q;
      `OFS_START: rd_d = start_q;
      default: begin
        if (grp == `GRP_MATCH && paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0) begin
          rd_d = match_q[paddr[4:2]];
        end else if (grp == `GRP_CAPCTRL && paddr[7:5] == 3'h4 && paddr[1:0] == 2'h0) begin
          rd_d[NEV-1:0] = capctrl_q[paddr[4:2]];
        end else if (grp == `GRP_EVENT && paddr[7:6] == 2'h0 && paddr[1:0] == 2'h0) begin
          if (paddr[2]) rd_d[23:0] = evctrl_q[paddr[5:3]];
          else rd_d[7:0] = evstate_q[paddr[5:3]];
        end else if (grp == `GRP_OUTACT && paddr[7:6] == 2'h0 && paddr[1:0] == 2'h0 &&
            paddr[5:3] < NOUT) begin
          if (paddr[2]) rd_d[NEV-1:0] = oclr_q[paddr[5:3]];
          else rd_d[NEV-1:0] = oset_q[paddr[5:3]];
        end else begin
          err_d = 1'b1;
        end
      end
    endcase
  end

  // apb: no wait state, ready registered from setup, data and error latched in setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        prdata_q <= pwrite ? 32'h00000000 : rd_d;
        pslverr_q <= err_d;
      end else if (pready_q) begin
        pslverr_q <= 1'b0;
      end
    end
  end

endmodule

/* tb/timer_pwm_sva.sv */
/* assertions on the event timer's apb and output ports.
   assumes binding to event_timer_pwm; helpers shadow a few written registers. */
`timescale 1ns/1ps
module timer_pwm_sva #(
  parameter NOUT = 6
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata_q,
  input wire logic pready_q,
  input wire logic pslverr_q,
  // outputs
  input wire logic [NOUT-1:0] timer_out_q,
  input wire logic adc_trig_q,
  input wire logic dma_req_q,
  input wire logic event_irq_q
);
  logic [2:0] sel_q;
  logic [31:0] irqen_q;
  logic wr_seen_q;
  logic trig_q;
  wire wr_take = psel && penable && pready_q && pwrite;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= 3'h0;
      irqen_q <= 32'h0;
      wr_seen_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      if (wr_take && paddr == 12'h028)
        sel_q <= pwdata[2:0];
      if (wr_take && paddr == 12'h02c)
        irqen_q <= pwdata;
      if (wr_take)
        wr_seen_q <= 1'b1;
      trig_q <= (sel_q < 3'h6) ? timer_out_q[sel_q] : 1'b0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready_q)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready_q |=> !pready_q)
    else $error("ready longer than one cycle");
  a_ready_has_cause: assert property (pready_q |-> $past(psel && !penable))
    else $error("ready without setup");
  a_err_with_ready: assert property (pslverr_q |-> pready_q)
    else $error("error without ready");
  a_write_reads_zero: assert property (pready_q && pwrite |-> prdata_q == 32'h0)
    else $error("read data on write");
  a_adc_trig_copy: assert property (adc_trig_q == trig_q)
    else $error("adc trigger not the selected output");
  a_quiet_until_write: assert property (!wr_seen_q |->
    timer_out_q == {NOUT{1'b0}} && !dma_req_q && !event_irq_q)
    else $error("activity before any configuration");
  a_irq_needs_enable: assert property (irqen_q == 0 && $past(irqen_q) == 0 |-> !event_irq_q)
    else $error("interrupt with nothing enabled");
  c_adcsel: cover property (wr_take && paddr == 12'h028);
  c_dma: cover property ($rose(dma_req_q));
  c_irq: cover property ($rose(event_irq_q));
  c_err: cover property (pslverr_q);
endmodule
bind event_timer_pwm timer_pwm_sva #(.NOUT(NOUT)) u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
  .timer_out_q(timer_out_q), .adc_trig_q(adc_trig_q), .dma_req_q(dma_req_q),
  .event_irq_q(event_irq_q));

/* tb/pin_source_model.sv */
/* far-side sources feeding the timer's input selectors.
   assumes the bench sets level_req just after a clock edge. */
`timescale 1ns/1ps
module pin_source_model (
  // control
  input wire logic pclk,
  input wire logic [7:0] level_req,
  // sources 0..7
  output logic [3:0] route_pin,
  output logic adc_thcmp_irq,
  output logic cmp_out,
  output logic core_event_out,
  output logic debug_halt_status
);
  initial begin
    {debug_halt_status, core_event_out, cmp_out, adc_thcmp_irq, route_pin} = 8'h00;
  end
  // levels move one edge late, unrelated to the design's sampling
  always @(posedge pclk) begin
    {debug_halt_status, core_event_out, cmp_out, adc_thcmp_irq, route_pin} <= level_req;
  end
endmodule

/* tb/tb_state_event_timer_pwm.sv */
/* self-checking bench: apb master, pin sources, pwm measurement.
   assumes a 200 mhz pclk and the designer's register map. */
`timescale 1ns/1ps
`include "timer_pwm_defines.vh"
module tb_state_event_timer_pwm;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, adc_trig_q, dma_req_q, event_irq_q;
  logic [3:0] route_pin;
  logic adc_thcmp_irq, cmp_out, core_event_out, debug_halt_status;
  logic [5:0] timer_out_q;
  logic [7:0] level_req = 8'h00;
  logic [31:0] seed = 32'h6935;
  logic [31:0] r, c1, c2;
  logic e;
  int n_mismatch = 0;
  int samples_checked = 0;
  int unsigned model[int];
  int d0, d1, hi0, hi1, hia, ndma, ndown;
  logic [31:0] evc[6] = '{32'h1000, 32'h1001, 32'h1002, 32'hd002, 32'h1003, 32'h2400};
  logic [7:0] evs[6] = '{8'h03, 8'h03, 8'h02, 8'h01, 8'h04, 8'h02};
  localparam int NPER = 20;

  initial begin
    forever #2.5 pclk = ~pclk;
  end

  event_timer_pwm DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .route_pin(route_pin),
    .adc_thcmp_irq(adc_thcmp_irq), .cmp_out(cmp_out), .core_event_out(core_event_out),
    .debug_halt_status(debug_halt_status), .timer_out_q(timer_out_q),
    .adc_trig_q(adc_trig_q), .dma_req_q(dma_req_q), .event_irq_q(event_irq_q));

  pin_source_model src (.pclk(pclk), .level_req(level_req), .route_pin(route_pin),
    .adc_thcmp_irq(adc_thcmp_irq), .cmp_out(cmp_out), .core_event_out(core_event_out),
    .debug_halt_status(debug_halt_status));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  // one transfer; leaves the bus in access so a setup may follow at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_q !== 1'b1 && n < 20);
    if (n >= 20)
      chk(32'h0, 32'h1);
    r = prdata_q;
    e = pslverr_q;
  endtask

  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    idle();
    model[a] = d;
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
    idle();
  endtask

  task automatic rd2();
    apb(1'b0, `OFS_COUNT, 32'h0);
    c1 = r;
    apb(1'b0, `OFS_COUNT, 32'h0);
    c2 = r;
    idle();
  endtask

  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 16; a++) begin
      rd(12'(4 * a));
      chk(r, (a == 1) ? `CTRL_RESET : `RESET_ZERO);
    end
    rd(12'h040);
    chk({31'h0, e}, 32'h1);
    for (int i = 0; i < 8; i++)
      wr(12'(12'h100 + 4 * i), rnd());
    for (int i = 0; i < 8; i++) begin
      rd(12'(12'h100 + 4 * i));
      chk(r, model[12'h100 + 4 * i]);
    end
    wr(`OFS_OUTPUT, rnd());
    rd(`OFS_OUTPUT);
    chk(r, model[`OFS_OUTPUT] & 32'h3f);
    for (int s = 0; s < 8; s++) begin
      wr(`OFS_INSEL, {20'h0, 3'((s + 3) % 8), 3'((s + 2) % 8), 3'((s + 1) % 8), 3'(s)});
      level_req <= 8'(rnd());
      repeat (6) @(posedge pclk);
      rd(`OFS_INPUT);
      chk(r, {28'h0, level_req[(s + 3) % 8], level_req[(s + 2) % 8],
        level_req[(s + 1) % 8], level_req[s]});
    end
    level_req <= 8'h00;
    wr(`OFS_INSEL, 32'h0);
    // one 32-bit counter carries, split low half wraps alone
    wr(`OFS_COUNT, 32'h0000fffe);
    wr(`OFS_CONFIG, 32'h1);
    wr(`OFS_CTRL, 32'h0);
    rd2();
    chk({16'h0, c2[31:16]}, 32'h1);
    chk(c2, c1 + 32'h2);
    wr(`OFS_CTRL, `CTRL_RESET);
    wr(`OFS_CONFIG, 32'h0);
    wr(`OFS_COUNT, 32'h0000fffe);
    wr(`OFS_CTRL, 32'h00020000);
    rd2();
    chk({c1[31:16], c2[31:16]}, 32'h0);
    chk({16'h0, c2[15:0]}, {16'h0, c1[15:0] + 16'h2});
    wr(`OFS_CTRL, `CTRL_RESET);
    // pwm: period from match 0, duties from matches 1 and 2
    d0 = 1 + int'(rnd() % 12);
    d1 = 13 + int'(rnd() % 5);
    wr(`OFS_CONFIG, 32'h11);
    wr(`OFS_COUNT, 32'h0);
    wr(`OFS_STATE, 32'h0);
    wr(`OFS_OUTPUT, 32'h0);
    wr(12'h100, NPER - 1);
    wr(12'h104, d0);
    wr(12'h108, d1);
    wr(12'h10c, 32'h7);
    wr(`OFS_REGMODE, 32'h80);
    wr(12'h19c, 32'h2);
    for (int i = 0; i < 6; i++) begin
      wr(12'(12'h200 + 8 * i), {24'h0, evs[i]});
      wr(12'(12'h204 + 8 * i), evc[i]);
    end
    wr(12'h300, 32'h1);
    wr(12'h304, 32'h2);
    wr(12'h308, 32'h1);
    wr(12'h30c, 32'h4);
    wr(12'h328, 32'h20);
    wr(`OFS_DMAEN, 32'h12);
    wr(`OFS_IRQEN, 32'h2);
    wr(`OFS_ADCSEL, 32'h1);
    wr(`OFS_CTRL, 32'h0);
    repeat (3 * NPER) @(posedge pclk);
    hi0 = 0;
    hi1 = 0;
    hia = 0;
    ndma = 0;
    repeat (5 * NPER) begin
      @(posedge pclk);
      hi0 += timer_out_q[0];
      hi1 += timer_out_q[1];
      hia += adc_trig_q;
      ndma += dma_req_q;
    end
    chk_n(hi0, 5 * (d0 + 1));
    chk_n(hi1, 5 * (d1 + 1));
    chk_n(hia, 5 * (d1 + 1));
    chk_n(ndma, 5);
    chk({31'h0, event_irq_q}, 32'h1);
    chk({31'h0, timer_out_q[5]}, 32'h0);
    level_req <= 8'h01;
    repeat (8) @(posedge pclk);
    chk({31'h0, timer_out_q[5]}, 32'h1);
    wr(`OFS_CTRL, 32'h2);
    wr(`OFS_COUNT, 32'd18);
    rd(`OFS_STATE);
    chk(r, 32'h1);
    rd(12'h11c);
    chk(r, d0);
    rd(`OFS_EVFLAG);
    chk(r, 32'h2f);
    wr(`OFS_EVFLAG, 32'hff);
    rd(`OFS_EVFLAG);
    chk(r, 32'h0);
    repeat (3) @(posedge pclk);
    chk({31'h0, event_irq_q}, 32'h0);
    rd(`OFS_COUNT);
    chk(r, 32'd18);
    // up-down: at least one pair of reads must show the count falling by two
    wr(`OFS_CTRL, 32'h8);
    ndown = 0;
    for (int k = 0; k < 20; k++) begin
      rd2();
      ndown += (c1 - c2 == 32'h2);
    end
    chk_n(ndown > 0, 1);
    test_done();
  end
endmodule
